// *** rtl/adc_ctrl_cfg.svh ***
// register map, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH
// byte addresses of the word-wide registers
`define OFS_MUX_SEL     8'h00
`define OFS_CTRL_A      8'h04
`define OFS_CTRL_B      8'h08
`define OFS_RES_LOW     8'h0C
`define OFS_RES_HIGH    8'h10
`define OFS_MISC        8'h14
// input_mux_select fields
`define MUX_REF_HI      7
`define MUX_REF_LO      6
`define MUX_LEFT_ADJ    5
`define MUX_CHAN_HI     4
// converter_control_a fields
`define CA_ENABLE       7
`define CA_START        6
`define CA_AUTO         5
`define CA_DONE         4
`define CA_IRQ_EN       3
`define CA_DIV_HI       2
// converter_control_b and analog_misc_control fields
`define CB_TRIG_HI      2
`define MISC_EXT_PIN    0
// reset values
`define RST_MUX_SEL     8'h00
`define RST_CTRL_A      8'h00
`define RST_CTRL_B      3'h0
`define RST_RESULT      10'h000
// conversion lengths in converter clock cycles
`define CYC_NORMAL      5'h0D
`define CYC_LONG        5'h19
`endif

// *** rtl/adc_ctrl_pkg.sv ***
// types shared by the converter control logic
package adc_ctrl_pkg;
  // converter reference choices
  typedef enum logic [1:0] {
    REF_AVCC    = 2'h0,
    REF_EXT_PIN = 2'h1,
    REF_INT_1V1 = 2'h2,
    REF_INT_2V56 = 2'h3
  } ref_e;
  // internal single-ended sources
  typedef enum logic [2:0] {
    SRC_PIN      = 3'h0,
    SRC_TEMP     = 3'h1,
    SRC_BANDGAP  = 3'h2,
    SRC_QUARTER  = 3'h3,
    SRC_GROUND   = 3'h4,
    SRC_RESERVED = 3'h5
  } int_src_e;
  // conversion sequencer, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_CONV = 2'h2
  } conv_state_e;
  // selection handed to the analog multiplexer and gain stage
  typedef struct packed {
    ref_e       ref_sel;
    int_src_e   int_src;
    logic       diff;
    logic       gain_20x;
    logic [3:0] pos_in;
    logic [3:0] neg_in;
  } analog_sel_s;
endpackage

// *** rtl/conv_prescaler.sv ***
// converter clock prescaler: one-cycle enable pulse every 2..128 system clocks
`timescale 1ns/1ps
`default_nettype none
module conv_prescaler #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       run_i,
  input  wire logic [2:0] div_sel_i,
  // converter clock enable
  output logic            tick_o
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] limit;

  // codes 0 and 1 both divide by two, others by a power of two
  assign limit  = (div_sel_i == 3'h0) ? CNT_W'(1)
                : CNT_W'((8'h01 << div_sel_i) - 8'h01); // [R16]
  assign tick_o = run_i && (cnt_ff == limit);

  // held at zero while idle so every conversion starts on a full period
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || tick_o) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end
endmodule // conv_prescaler
`default_nettype wire

// *** rtl/adc_mux_and_control_regs.sv ***
// converter input selection, control register and conversion sequencing on wishbone
// Functional notes
// [R1] reference bits plus pin enable pick reference
// [R2] reference change waits for running conversion
// [R3] conversion after reference change takes 25
// [R4] left-adjust bit selects result alignment
// [R5] alignment change shows on reads immediately
// [R6] channel change waits for running conversion
// [R7] low channel codes: pins, sensors, ground
// [R8] differential codes: even 8x, odd 20x
// [R9] differential pairs follow fixed pin order
// [R10] enable powers converter, clear aborts conversion
// [R11] single mode: start per conversion; free once
// [R12] first conversion after enable takes 25
// [R13] start reads busy, self-clears, zero ignored
// [R14] auto trigger starts on source rising edge
// [R15] completion sets flag, write-one or vector clears
// [R16] divider codes give 2,2,4..128
// [R17] low read locks result until high read
// [R18] trigger source field picks among eight
// [R19] all register bits reset to zero
// [R20] free running restarts after each completion
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_cfg.svh"
module adc_mux_and_control_regs #(
  parameter int RES_W = 10
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // wishbone slave
  input  wire logic [7:0]              adr_i,
  input  wire logic [31:0]             dat_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic                    we_i,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  output logic [31:0]                  dat_o,
  output logic                         ack_o,
  // converter core and trigger sources
  input  wire logic [RES_W-1:0]        conv_result_i,
  input  wire logic [6:0]              trig_src_i,
  input  wire logic                    irq_vector_ack_i,
  // to analog side
  output adc_ctrl_pkg::analog_sel_s    analog_sel_o,
  output logic                         adc_power_o,
  output logic                         conv_busy_o,
  output logic                         conv_step_o,
  output logic                         conv_init_o,
  output logic                         done_irq_req_o
);
  // register state
  logic [7:0]                      mux_ff;
  logic                            ext_pin_ff;
  logic                            en_ff;
  logic                            auto_ff;
  logic                            done_ff;
  logic                            ie_ff;
  logic [2:0]                      div_ff;
  logic [2:0]                      trig_sel_ff;
  logic [RES_W-1:0]                res_ff;
  logic                            lock_ff;
  logic                            ack_ff;
  logic [31:0]                     dat_ff;
  // conversion state
  adc_ctrl_pkg::conv_state_e       state_ff;
  adc_ctrl_pkg::conv_state_e       nxt_state;
  logic [4:0]                      cnt_ff;
  logic [4:0]                      len_ff;
  logic                            init_pend_ff;
  logic                            ref_pend_ff;
  logic [1:0]                      act_ref_ff;
  adc_ctrl_pkg::analog_sel_s       sel_ff;
  adc_ctrl_pkg::analog_sel_s       nxt_sel;
  logic                            trig_prev_ff;

  // bus decode
  logic        acc;
  logic        wr;
  logic        rd;
  logic        wr_mux;
  logic        wr_ca;
  logic        wr_cb;
  logic        wr_misc;
  logic        rd_low;
  logic        rd_high;
  logic [7:0]  wb;
  logic [31:0] rdata;
  logic [7:0]  res_low;
  logic [7:0]  res_high;

  // a request is taken once; ack blocks the held request from being seen twice
  assign acc     = cyc_i && stb_i && !ack_ff;
  assign wr      = acc && we_i && sel_i[0];
  assign rd      = acc && !we_i;
  assign wb      = dat_i[7:0];
  assign wr_mux  = wr && (adr_i == `OFS_MUX_SEL);
  assign wr_ca   = wr && (adr_i == `OFS_CTRL_A);
  assign wr_cb   = wr && (adr_i == `OFS_CTRL_B);
  assign wr_misc = wr && (adr_i == `OFS_MISC);
  assign rd_low  = rd && (adr_i == `OFS_RES_LOW);
  assign rd_high = rd && (adr_i == `OFS_RES_HIGH);

  // result presentation follows the live left-adjust bit
  assign res_low  = mux_ff[`MUX_LEFT_ADJ] ? {res_ff[1:0], 6'h00} : res_ff[7:0];      // [R4] [R5]
  assign res_high = mux_ff[`MUX_LEFT_ADJ] ? res_ff[9:2] : {6'h00, res_ff[9:8]};      // [R4] [R5]

  // read data mux; unmapped addresses read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (adr_i)
      `OFS_MUX_SEL:  rdata[7:0] = mux_ff;
      `OFS_CTRL_A:   rdata[7:0] = {en_ff, conv_busy_o, auto_ff, done_ff, ie_ff, div_ff}; // [R13]
      `OFS_CTRL_B:   rdata[2:0] = trig_sel_ff;
      `OFS_RES_LOW:  rdata[7:0] = res_low;
      `OFS_RES_HIGH: rdata[7:0] = res_high;
      `OFS_MISC:     rdata[0]   = ext_pin_ff;
      default:       rdata = 32'h0000_0000;
    endcase
  end

  // bus answer one cycle after the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= acc;
      if (rd) begin
        dat_ff <= rdata;
      end
    end
  end
  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  // converter clock
  logic tick;
  conv_prescaler #(.CNT_W(7)) u_presc (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (state_ff == adc_ctrl_pkg::ST_CONV),
    .div_sel_i (div_ff),
    .tick_o    (tick)
  );

  // sequencing terms
  logic       busy;
  logic       nxt_en;
  logic       en_rise;
  logic       conv_done;
  logic       trig_lvl;
  logic [7:0] trig_vec;
  logic       free_run;
  logic       sw_start;
  logic       hw_start;
  logic       fr_restart;
  logic       start;
  logic       apply;
  logic       ref_chg;
  logic       need_long;

  assign busy       = (state_ff == adc_ctrl_pkg::ST_CONV);
  assign nxt_en     = wr_ca ? wb[`CA_ENABLE] : en_ff;
  assign en_rise    = nxt_en && !en_ff;
  assign conv_done  = busy && en_ff && tick && (cnt_ff == len_ff - 5'h01);
  // code 0 is free running and has no trigger line of its own
  assign trig_vec   = {trig_src_i, 1'b0};
  assign trig_lvl   = trig_vec[trig_sel_ff];                            // [R18]
  assign free_run   = auto_ff && (trig_sel_ff == 3'h0);
  // writing zero to start does nothing; a start while busy is absorbed
  assign sw_start   = wr_ca && wb[`CA_START] && nxt_en && !busy;        // [R11] [R13]
  assign hw_start   = auto_ff && en_ff && trig_lvl && !trig_prev_ff && !busy; // [R14]
  assign fr_restart = conv_done && free_run && nxt_en;                  // [R20]
  assign start      = sw_start || hw_start || fr_restart;
  // selection only moves between conversions
  assign apply      = !busy || conv_done;                               // [R2] [R6]
  assign ref_chg    = apply && (mux_ff[`MUX_REF_HI:`MUX_REF_LO] != act_ref_ff);
  assign need_long  = init_pend_ff || en_rise || ref_pend_ff || ref_chg; // [R3] [R12]

  // channel, gain and reference decode from the software fields
  logic [4:0] ch;
  assign ch = mux_ff[`MUX_CHAN_HI:0];
  always_comb begin
    nxt_sel          = '0;
    nxt_sel.diff     = ch[4];
    nxt_sel.gain_20x = ch[4] && ch[0];                                  // [R8]
    // the unlisted combination internal-with-pin-enable falls back to the pin
    if (ext_pin_ff) begin
      nxt_sel.ref_sel = adc_ctrl_pkg::REF_EXT_PIN;                      // [R1]
    end else if (!mux_ff[`MUX_REF_LO]) begin
      nxt_sel.ref_sel = adc_ctrl_pkg::REF_AVCC;                         // [R1]
    end else if (mux_ff[`MUX_REF_HI]) begin
      nxt_sel.ref_sel = adc_ctrl_pkg::REF_INT_2V56;                     // [R1]
    end else begin
      nxt_sel.ref_sel = adc_ctrl_pkg::REF_INT_1V1;                      // [R1]
    end
    if (ch[4]) begin
      case (ch[3:1])                                                    // [R9]
        3'h0:    nxt_sel.pos_in = 4'h0;
        3'h1:    nxt_sel.pos_in = 4'h1;
        3'h2:    nxt_sel.pos_in = 4'h2;
        3'h3:    nxt_sel.pos_in = 4'h4;
        3'h4:    nxt_sel.pos_in = 4'h5;
        3'h5:    nxt_sel.pos_in = 4'h6;
        3'h6:    nxt_sel.pos_in = 4'h8;
        default: nxt_sel.pos_in = 4'h9;
      endcase
      nxt_sel.neg_in = nxt_sel.pos_in + 4'h1;                           // [R9]
    end else begin
      case (ch[3:0])                                                    // [R7]
        4'hB:    nxt_sel.int_src = adc_ctrl_pkg::SRC_TEMP;
        4'hC:    nxt_sel.int_src = adc_ctrl_pkg::SRC_BANDGAP;
        4'hD:    nxt_sel.int_src = adc_ctrl_pkg::SRC_QUARTER;
        4'hE:    nxt_sel.int_src = adc_ctrl_pkg::SRC_GROUND;
        4'hF:    nxt_sel.int_src = adc_ctrl_pkg::SRC_RESERVED;
        default: nxt_sel.pos_in  = ch[3:0];
      endcase
    end
  end

  // software registers; all fields clear at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mux_ff      <= `RST_MUX_SEL;                                      // [R19]
      ext_pin_ff  <= 1'b0;
      {en_ff, auto_ff, ie_ff, div_ff} <= 6'(`RST_CTRL_A);               // [R19]
      trig_sel_ff <= `RST_CTRL_B;
    end else begin
      if (wr_mux) mux_ff <= wb;
      if (wr_misc) ext_pin_ff <= wb[`MISC_EXT_PIN];
      if (wr_cb) trig_sel_ff <= wb[`CB_TRIG_HI:0];
      if (wr_ca) begin
        en_ff   <= wb[`CA_ENABLE];                                      // [R10]
        auto_ff <= wb[`CA_AUTO];
        ie_ff   <= wb[`CA_IRQ_EN];
        div_ff  <= wb[`CA_DIV_HI:0];
      end
    end
  end

  // done flag: completion wins over a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
    end else if (conv_done) begin
      done_ff <= 1'b1;                                                  // [R15]
    end else if ((wr_ca && wb[`CA_DONE]) || irq_vector_ack_i) begin
      done_ff <= 1'b0;                                                  // [R15]
    end
  end

  // result capture; a pending low-byte read freezes it, the new result is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_ff  <= `RST_RESULT;
      lock_ff <= 1'b0;
    end else begin
      if (conv_done && !lock_ff) res_ff <= conv_result_i;               // [R15] [R17]
      if (rd_high) begin
        lock_ff <= 1'b0;                                                // [R17]
      end else if (rd_low) begin
        lock_ff <= 1'b1;                                                // [R17]
      end
    end
  end

  // sequencer next state; clearing enable aborts
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      adc_ctrl_pkg::ST_IDLE: if (start) nxt_state = adc_ctrl_pkg::ST_CONV;
      adc_ctrl_pkg::ST_CONV: begin
        if (!en_ff) begin
          nxt_state = adc_ctrl_pkg::ST_IDLE;                            // [R10]
        end else if (conv_done && !fr_restart) begin
          nxt_state = adc_ctrl_pkg::ST_IDLE;
        end
      end
      default: nxt_state = adc_ctrl_pkg::ST_IDLE;
    endcase
  end

  // sequencer, cycle count and pending long-conversion causes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff     <= adc_ctrl_pkg::ST_IDLE;
      cnt_ff       <= 5'h00;
      len_ff       <= `CYC_NORMAL;
      init_pend_ff <= 1'b0;
      ref_pend_ff  <= 1'b0;
      trig_prev_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      trig_prev_ff <= trig_lvl;
      if (start) begin
        cnt_ff <= 5'h00;
        len_ff <= need_long ? `CYC_LONG : `CYC_NORMAL;                  // [R3] [R12]
      end else if (busy && tick) begin
        cnt_ff <= cnt_ff + 5'h01;
      end
      init_pend_ff <= !start && (init_pend_ff || en_rise) && nxt_en;    // [R12]
      ref_pend_ff  <= !start && (ref_pend_ff || ref_chg);               // [R3]
    end
  end

  // applied selection held stable through a conversion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_ff     <= '0;
      act_ref_ff <= 2'h0;
    end else if (apply) begin
      sel_ff     <= nxt_sel;                                            // [R2] [R6]
      act_ref_ff <= mux_ff[`MUX_REF_HI:`MUX_REF_LO];
    end
  end

  // analog side outputs
  assign analog_sel_o   = sel_ff;
  assign adc_power_o    = en_ff;                                        // [R10]
  assign conv_busy_o    = busy;                                         // [R13]
  assign conv_step_o    = busy && tick;
  assign conv_init_o    = busy && (len_ff == `CYC_LONG);
  assign done_irq_req_o = done_ff && ie_ff;

  // checks
  done_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    conv_done |=> done_ff) else $error("done flag not set on completion");
  abort_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (busy && !en_ff) |=> !busy) else $error("conversion not aborted when disabled");
  chan_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (busy && !conv_done) |=> $stable(sel_ff.pos_in) && $stable(sel_ff.neg_in))
    else $error("channel changed during conversion");
  ref_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (busy && !conv_done) |=> $stable(act_ref_ff)) else $error("reference changed mid conversion");
  long_first_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    (start && en_rise) |=> (len_ff == 5'h19)) else $error("first conversion not 25 cycles");
  long_ref_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (start && ref_chg) |=> (len_ff == 5'h19)) else $error("reference change not long");
  normal_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    (start && !need_long) |=> (len_ff == 5'h0D)) else $error("normal conversion not 13");
  result_lock_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    (lock_ff && !rd_high) |=> $stable(res_ff)) else $error("result updated while locked");
  left_align_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    mux_ff[5] |-> (res_high == res_ff[9:2])) else $error("left alignment wrong");
  free_run_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
    (conv_done && free_run && en_ff && !wr_ca) |=> busy) else $error("free run did not restart");
  zero_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    (wr_ca && !wb[6] && !busy && !hw_start) |=> !busy) else $error("zero start began a conversion");
  trig_edge_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    (hw_start) |=> busy ##0 $past(trig_lvl)) else $error("trigger edge missed");
endmodule // adc_mux_and_control_regs
`default_nettype wire

// *** tb/conv_core_model.sv ***
// behavioural converter core: a new sample per busy period, step count for the bench
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // from the control block
  input  wire logic        busy_i,
  input  wire logic        step_i,
  // result lines and bench view
  output logic [9:0]       result_o,
  output logic [9:0]       value_o,
  output logic [15:0]      steps_o
);
  logic busy_q_ff;
  // valid only while converting; inverted outside so a stale capture shows up
  assign result_o = busy_i ? value_o : ~value_o;
  // maximal 10-bit lfsr steps once per rise of busy_i; converter clocks are counted
  always_ff @(posedge clk_i) begin
    busy_q_ff <= busy_i & ~rst_i;
    if (rst_i) begin
      value_o <= 10'h2B5;
      steps_o <= 16'h0;
    end else if (busy_i && !busy_q_ff) begin
      value_o <= {value_o[8:0], value_o[9] ^ value_o[6]};
      steps_o <= {15'h0, step_i};
    end else if (busy_i && step_i) begin
      steps_o <= steps_o + 16'h1;
    end
  end
endmodule // conv_core_model
`default_nettype wire

// *** tb/test_adc_mux_and_control_regs.sv ***
// self-checking bench for the converter control block against a behavioural core
`timescale 1ns/1ps
`default_nettype none
module test_adc_mux_and_control_regs;
  // stimulus
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0]  sel_i = 4'h0;
  logic        we_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic [6:0]  trig_src_i = 7'h00;
  logic        irq_vector_ack_i = 1'b0;
  // design outputs and core model
  wire  [31:0] dat_o;
  wire         ack_o, adc_power_o, conv_busy_o, conv_step_o, conv_init_o, done_irq_req_o;
  adc_ctrl_pkg::analog_sel_s analog_sel_o;
  wire  [9:0]  conv_result_i;
  wire  [9:0]  core_value;
  wire  [15:0] core_steps;
  // bench state
  logic [15:0] busy_len = 16'h0;
  logic        busy_q = 1'b0;
  logic [31:0] rd;
  logic [31:0] rnd;
  logic [31:0] rng = 32'd71281;
  logic [9:0]  keep;
  logic [7:0]  mux;
  int          n_errors = 0;
  int          check_count = 0;

  always #25 clk_i = ~clk_i;

  adc_mux_and_control_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .conv_result_i(conv_result_i), .trig_src_i(trig_src_i),
    .irq_vector_ack_i(irq_vector_ack_i), .analog_sel_o(analog_sel_o),
    .adc_power_o(adc_power_o), .conv_busy_o(conv_busy_o), .conv_step_o(conv_step_o),
    .conv_init_o(conv_init_o), .done_irq_req_o(done_irq_req_o));
  conv_core_model core (.clk_i(clk_i), .rst_i(rst_i), .busy_i(conv_busy_o),
    .step_i(conv_step_o), .result_o(conv_result_i), .value_o(core_value),
    .steps_o(core_steps));

  // length of the last busy period in system clocks
  always @(posedge clk_i) begin
    busy_q <= conv_busy_o;
    if (conv_busy_o && !busy_q) busy_len <= 16'h1;
    else if (conv_busy_o) busy_len <= busy_len + 16'h1;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // selection expected for a mux byte and pin enable; pairs skip every fourth pin
  function automatic adc_ctrl_pkg::analog_sel_s exp_sel(input logic [7:0] m, input logic e);
    adc_ctrl_pkg::analog_sel_s s;
    logic [3:0] p;
    s = '0;
    p = {1'b0, m[3:1]} + {1'b0, m[3:1]} / 4'h3;
    s.ref_sel = adc_ctrl_pkg::ref_e'(e ? 2'h1 : m[6] ? {1'b1, m[7]} : 2'h0);
    s.int_src = adc_ctrl_pkg::int_src_e'(m[3:0] > 4'hA ? 3'(m[3:0] - 4'hA) : 3'h0);
    // internal sources leave the pin index at zero
    s.pos_in = (m[3:0] > 4'hA) ? 4'h0 : m[3:0];
    if (m[4]) begin
      s = '0;
      s.ref_sel = adc_ctrl_pkg::ref_e'(e ? 2'h1 : m[6] ? {1'b1, m[7]} : 2'h0);
      s.diff = 1'b1;
      s.gain_20x = m[0];
      s.pos_in = p;
      s.neg_in = p + 4'h1;
    end
    return s;
  endfunction
  // result byte as read: hi selects the upper register
  function automatic logic [31:0] res_rd(input logic [9:0] r, input logic adj, input logic hi);
    if (adj) return {24'h0, hi ? r[9:2] : {r[1:0], 6'h0}};
    return {24'h0, hi ? {6'h0, r[9:8]} : r[7:0]};
  endfunction

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_sel(input adc_ctrl_pkg::analog_sel_s got, exp);
    chk_reg(32'(got), 32'(exp));
  endtask
  task automatic chk_n(input logic [15:0] got, input logic [15:0] exp);
    chk_reg({16'h0, got}, {16'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one classic wishbone cycle; read data taken at the ack edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
                    input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    adr_i <= a;
    we_i <= w;
    dat_i <= {24'h0, d};
    sel_i <= s;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    // no wait limit here: only the watchdog ends a hung cycle
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 8'h00);
    chk_reg(rd, exp);
  endtask
  // bounded wait for the sequencer to fall idle, then let counters settle
  task automatic wait_idle();
    int n;
    n = 0;
    while (conv_busy_o !== 1'b0 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 5000) n_errors++;
    @(posedge clk_i);
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    cyc(16);
    rst_i <= 1'b0;
    chk_sel(analog_sel_o, '0);
    for (int a = 0; a < 28; a += 4) rdchk(8'(a), 32'h0);
    for (int i = 0; i < 128; i++) begin
      rnd = xs();
      mux = {i[6:5], rnd[1], i[4:0]};
      wb(8'h14, 1'b1, {7'h0, rnd[0]});
      wb(8'h00, 1'b1, mux);
      rdchk(8'h00, {24'h0, mux});
      chk_sel(analog_sel_o, exp_sel(mux, rnd[0]));
    end
    wb(8'h00, 1'b1, 8'h00, 4'hE);
    rdchk(8'h00, {24'h0, mux});
    wb(8'h00, 1'b1, 8'h00);
    wb(8'h14, 1'b1, 8'h00);
    wb(8'h04, 1'b1, 8'h80);
    chk_n({14'h0, adc_power_o, conv_busy_o}, 16'h2);
    wb(8'h04, 1'b1, 8'hC0);
    rdchk(8'h04, 32'hC0);
    chk_n({15'h0, conv_init_o}, 16'h1);
    wait_idle();
    chk_n(core_steps, 16'd25);
    chk_n(busy_len, 16'd50);
    rdchk(8'h04, 32'h90);
    keep = core_value;
    for (int j = 0; j < 4; j++) begin
      wb(8'h00, 1'b1, {2'b0, j[1], 5'h0});
      rdchk(j[0] ? 8'h10 : 8'h0C, res_rd(keep, j[1], j[0]));
    end
    for (int d = 0; d < 8; d++) begin
      wb(8'h04, 1'b1, 8'hD0 | 8'(d));
      rdchk(8'h04, 32'hC0 | d);
      wait_idle();
      chk_n(core_steps, 16'd13);
      chk_n(busy_len, 16'(13 * (d == 0 ? 2 : 1 << d)));
      rdchk(8'h04, 32'h90 | d);
    end
    keep = core_value;
    wb(8'h04, 1'b1, 8'hC7);
    wb(8'h00, 1'b1, 8'h45);
    rdchk(8'h0C, res_rd(keep, 1'b0, 1'b0));
    rdchk(8'h10, res_rd(keep, 1'b0, 1'b1));
    chk_sel(analog_sel_o, exp_sel(8'h20, 1'b0));
    wait_idle();
    chk_sel(analog_sel_o, exp_sel(8'h45, 1'b0));
    keep = core_value;
    rdchk(8'h0C, res_rd(keep, 1'b0, 1'b0));
    wb(8'h04, 1'b1, 8'hC0);
    wait_idle();
    chk_n(core_steps, 16'd25);
    rdchk(8'h10, res_rd(keep, 1'b0, 1'b1));
    rdchk(8'h0C, res_rd(keep, 1'b0, 1'b0));
    rdchk(8'h10, res_rd(keep, 1'b0, 1'b1));
    wb(8'h04, 1'b1, 8'h88);
    cyc(1);
    chk_n({15'h0, done_irq_req_o}, 16'h1);
    irq_vector_ack_i <= 1'b1;
    cyc(1);
    irq_vector_ack_i <= 1'b0;
    cyc(2);
    chk_n({15'h0, done_irq_req_o}, 16'h0);
    rdchk(8'h04, 32'h88);
    wb(8'h04, 1'b1, 8'hC7);
    cyc(40);
    wb(8'h04, 1'b1, 8'h07);
    cyc(3);
    chk_n({14'h0, conv_busy_o, adc_power_o}, 16'h0);
    rdchk(8'h04, 32'h07);
    wb(8'h04, 1'b1, 8'hC0);
    wait_idle();
    chk_n(core_steps, 16'd25);
    for (int k = 1; k < 8; k++) begin
      wb(8'h08, 1'b1, 8'(k));
      wb(8'h04, 1'b1, 8'hB0);
      trig_src_i <= 7'(1 << (k % 7));
      cyc(4);
      chk_n({15'h0, conv_busy_o}, 16'h0);
      trig_src_i <= trig_src_i | 7'(1 << (k - 1));
      cyc(4);
      chk_n({15'h0, conv_busy_o}, 16'h1);
      wait_idle();
      trig_src_i <= 7'h00;
    end
    wb(8'h08, 1'b1, 8'h00);
    wb(8'h04, 1'b1, 8'hF0);
    cyc(200);
    rdchk(8'h04, 32'hF0);
    wb(8'h04, 1'b1, 8'h80);
    cyc(40);
    chk_n({15'h0, conv_busy_o}, 16'h0);
    print_verdict();
  end

  // watchdog well beyond the expected run length
  initial begin
    #(50 * 60000);
    n_errors++;
    print_verdict();
  end
endmodule // test_adc_mux_and_control_regs
`default_nettype wire
